// file: rtl/speed_sel_pkg.sv
package speed_sel_pkg;

  // frequencies are in 0.1 Hz steps, ramp times in 0.1 s steps
  localparam int                FREQ_W          = 16;
  localparam int                NUM_PRESETS     = 15;
  localparam int                NUM_TERMINALS   = 5;
  localparam int                CODE_W          = 4;
  localparam logic [15:0]       FREQ_MAX        = 16'h0FA0;  // 400.0 Hz
  localparam logic [15:0]       NOT_SELECTED    = 16'h270F;  // 9999
  localparam logic [15:0]       RAMP_TIME_MAX   = 16'h8CA0;  // 3600.0 s

  // preset slots: 0 high, 1 middle, 2 low, 3..14 speeds four to fifteen
  localparam logic [3:0]        SLOT_HIGH       = 4'h0;
  localparam logic [3:0]        SLOT_MIDDLE     = 4'h1;
  localparam logic [3:0]        SLOT_LOW        = 4'h2;
  localparam logic [15:0]       RST_HIGH_FREQ   = 16'h0258;  // 60.0 Hz
  localparam logic [15:0]       RST_MIDDLE_FREQ = 16'h012C;  // 30.0 Hz
  localparam logic [15:0]       RST_LOW_FREQ    = 16'h0064;  // 10.0 Hz
  localparam logic [15:0]       RST_JOG_FREQ    = 16'h0032;  // 5.0 Hz
  localparam logic [15:0]       RST_JOG_TIME    = 16'h0005;  // 0.5 s
  localparam logic [15:0]       RST_RAMP_REF    = 16'h0258;  // 60.0 Hz

  // speed number per selector pattern {extension, high, middle, low}
  localparam logic [15:0][3:0]  COMBO_SPEED     = {4'hF, 4'hE, 4'hD, 4'hC,
                                                   4'hB, 4'hA, 4'h9, 4'h8,
                                                   4'h7, 4'h6, 4'h5, 4'h1,
                                                   4'h4, 4'h2, 4'h3, 4'h0};
  localparam logic [3:0]        SPEED_HIGH      = 4'h1;
  localparam logic [3:0]        SPEED_MIDDLE    = 4'h2;
  localparam logic [3:0]        SPEED_LOW       = 4'h3;
  localparam logic [3:0]        SPEED_FIRST_EXT = 4'h4;

  // input terminal function codes
  localparam logic [3:0]        CODE_LOW        = 4'h0;
  localparam logic [3:0]        CODE_MIDDLE     = 4'h1;
  localparam logic [3:0]        CODE_HIGH       = 4'h2;
  localparam logic [3:0]        CODE_SECOND     = 4'h3;
  localparam logic [3:0]        CODE_JOG        = 4'h5;
  localparam logic [3:0]        CODE_EXTENSION  = 4'h8;
  localparam logic [19:0]       RST_TERM_CODES  = 20'h53210;

  // operation mode, remote selection and write selection codes
  localparam logic [2:0]        MODE_EXTERNAL   = 3'h2;
  localparam logic [2:0]        MODE_COMBINED3  = 3'h3;
  localparam logic [2:0]        MODE_COMBINED4  = 3'h4;
  localparam logic [2:0]        MODE_MAX        = 3'h4;
  localparam logic [2:0]        RST_MODE        = 3'h0;
  localparam logic [1:0]        REMOTE_MAX      = 2'h3;
  localparam logic [1:0]        WRITE_STOPPED   = 2'h0;
  localparam logic [1:0]        WRITE_ANY       = 2'h2;

  // register byte offsets
  localparam logic [7:0]        OFS_CONTROL     = 8'h00;
  localparam logic [7:0]        OFS_TERMINALS   = 8'h04;
  localparam logic [7:0]        OFS_JOG_FREQ    = 8'h08;
  localparam logic [7:0]        OFS_JOG_TIME    = 8'h0C;
  localparam logic [7:0]        OFS_RAMP_REF    = 8'h10;
  localparam logic [7:0]        OFS_STATUS      = 8'h14;
  localparam logic [7:0]        OFS_COMMAND     = 8'h18;
  localparam logic [7:0]        OFS_PRESET_BASE = 8'h40;
  localparam logic [7:0]        OFS_PRESET_LAST = 8'h78;

  // control register fields
  localparam int                CTL_MODE_LSB    = 0;
  localparam int                CTL_REMOTE_LSB  = 4;
  localparam int                CTL_WRITE_LSB   = 8;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_JOG,
    SRC_MULTI,
    SRC_CURRENT,
    SRC_VOLTAGE
  } source_e;

endpackage

// file: rtl/preset_lookup_if.sv
`timescale 1ns/1ps
`default_nettype none

interface preset_lookup_if;
  logic [3:0]  sel;        // {extension, high, middle, low}
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [15:0] wr_data;
  logic [3:0]  rd_idx;
  logic [15:0] rd_data;
  logic [15:0] sel_freq;
  logic        sel_valid;
  logic [3:0]  sel_speed;

  modport ctrl   (output sel, wr_en, wr_idx, wr_data, rd_idx,
                  input  rd_data, sel_freq, sel_valid, sel_speed);
  modport lookup (input  sel, wr_en, wr_idx, wr_data, rd_idx,
                  output rd_data, sel_freq, sel_valid, sel_speed);
endinterface

`default_nettype wire

// file: rtl/preset_lookup.sv
`timescale 1ns/1ps
`default_nettype none

module preset_lookup (
  // clock and reset
  input wire logic            core_clk_i,
  input wire logic            reset_i,
  // preset table port
  preset_lookup_if.lookup     lk
);

  typedef struct packed {
    logic [speed_sel_pkg::NUM_PRESETS-1:0][15:0] presets;
  } lookup_s;

  lookup_s state;
  lookup_s next_state;

  ////////////////////////////////////////////////////////////////////////
  // reset image: single speeds get their defaults, the rest not selected;
  // a constant, so the asynchronous reset branch loads no logic output
  localparam lookup_s RESET_STATE = '{
    presets: {{(speed_sel_pkg::NUM_PRESETS-3){speed_sel_pkg::NOT_SELECTED}},
              speed_sel_pkg::RST_LOW_FREQ,
              speed_sel_pkg::RST_MIDDLE_FREQ,
              speed_sel_pkg::RST_HIGH_FREQ}
  };

  // table update; the controller has already range checked the value
  always_comb begin
    next_state = state;
    if (lk.wr_en && lk.wr_idx < 4'(speed_sel_pkg::NUM_PRESETS)) begin
      next_state.presets[lk.wr_idx] = lk.wr_data;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // speed resolution: pattern table, then fall back on unset presets
  function automatic logic [3:0] resolve(input logic [3:0] sel,
                                         input lookup_s    st);
    logic [3:0] combo;
    logic [3:0] single;
    combo  = speed_sel_pkg::COMBO_SPEED[sel];
    // lowest-ranked single input wins when a pattern has no own speed
    single = sel[0] ? speed_sel_pkg::SPEED_LOW :
             sel[1] ? speed_sel_pkg::SPEED_MIDDLE :
             sel[2] ? speed_sel_pkg::SPEED_HIGH : speed_sel_pkg::SPEED_LOW;
    if (combo >= speed_sel_pkg::SPEED_FIRST_EXT &&
        st.presets[combo - 4'h1] == speed_sel_pkg::NOT_SELECTED) begin
      resolve = single;
    end else begin
      resolve = combo;
    end
  endfunction

  assign lk.sel_valid = (lk.sel != 4'h0);
  assign lk.sel_speed = lk.sel_valid ? resolve(lk.sel, state) : 4'h0;
  assign lk.sel_freq  = lk.sel_valid ? state.presets[lk.sel_speed - 4'h1] : 16'h0000;
  assign lk.rd_data   = (lk.rd_idx < 4'(speed_sel_pkg::NUM_PRESETS)) ?
                        state.presets[lk.rd_idx] : 16'h0000;

endmodule

`default_nettype wire

// file: rtl/terminal_speed_command_selector.sv
`timescale 1ns/1ps
`default_nettype none

module terminal_speed_command_selector (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // contact inputs
  input  wire logic [4:0]  terminal_i,
  input  wire logic        forward_start_i,
  input  wire logic        reverse_start_i,
  // operator panel
  input  wire logic        panel_jog_mode_i,
  input  wire logic        panel_run_i,
  // analog frequency commands
  input  wire logic        current_analog_en_i,
  input  wire logic [15:0] current_analog_freq_i,
  input  wire logic [15:0] voltage_analog_freq_i,
  // frequency command
  output logic      [15:0] freq_command_o,
  output logic      [2:0]  command_source_o,
  output logic      [3:0]  speed_number_o,
  output logic             run_o,
  output logic             reverse_o,
  // ramp control
  output logic             jog_active_o,
  output logic      [15:0] jog_accel_time_o,
  output logic      [15:0] jog_decel_time_o,
  output logic      [15:0] ramp_ref_freq_o,
  output logic             second_function_o,
  output logic             second_ramp_o,
  // remote setting commands
  output logic             remote_up_o,
  output logic             remote_down_o,
  output logic             remote_clear_o
);

  typedef struct packed {
    logic [2:0]              op_mode;
    logic [1:0]              remote_sel;
    logic [1:0]              write_sel;
    logic [19:0]             term_codes;
    logic [15:0]             jog_freq;
    logic [15:0]             jog_time;
    logic [15:0]             ramp_ref;
    logic                    reject;
    logic                    waitrequest;
    logic [31:0]             readdata;
    logic [15:0]             freq_cmd;
    speed_sel_pkg::source_e  source;
    logic [3:0]              speed;
    logic                    run;
    logic                    reverse;
    logic                    jog_active;
    logic                    second_fn;
    logic                    second_ramp;
    logic                    remote_up;
    logic                    remote_down;
    logic                    remote_clear;
  } ctrl_s;

  localparam ctrl_s RESET_STATE = '{
    op_mode:      speed_sel_pkg::RST_MODE,
    remote_sel:   2'h0,
    write_sel:    speed_sel_pkg::WRITE_STOPPED,
    term_codes:   speed_sel_pkg::RST_TERM_CODES,
    jog_freq:     speed_sel_pkg::RST_JOG_FREQ,
    jog_time:     speed_sel_pkg::RST_JOG_TIME,
    ramp_ref:     speed_sel_pkg::RST_RAMP_REF,
    reject:       1'b0,
    waitrequest:  1'b1,
    readdata:     32'h0000_0000,
    freq_cmd:     16'h0000,
    source:       speed_sel_pkg::SRC_NONE,
    speed:        4'h0,
    run:          1'b0,
    reverse:      1'b0,
    jog_active:   1'b0,
    second_fn:    1'b0,
    second_ramp:  1'b0,
    remote_up:    1'b0,
    remote_down:  1'b0,
    remote_clear: 1'b0
  };

  ctrl_s state;
  ctrl_s next_state;

  preset_lookup_if lk ();

  preset_lookup u_preset_lookup (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .lk         (lk)
  );

  ////////////////////////////////////////////////////////////////////////
  // terminal routing by function code
  logic [4:0] hit_low;
  logic [4:0] hit_middle;
  logic [4:0] hit_high;
  logic [4:0] hit_ext;
  logic [4:0] hit_jog;
  logic [4:0] hit_second;

  for (genvar t = 0; t < speed_sel_pkg::NUM_TERMINALS; t++) begin : g_term
    logic [3:0] code;
    assign code          = state.term_codes[t*speed_sel_pkg::CODE_W +: speed_sel_pkg::CODE_W];
    assign hit_low[t]    = terminal_i[t] && code == speed_sel_pkg::CODE_LOW;
    assign hit_middle[t] = terminal_i[t] && code == speed_sel_pkg::CODE_MIDDLE;
    assign hit_high[t]   = terminal_i[t] && code == speed_sel_pkg::CODE_HIGH;
    assign hit_ext[t]    = terminal_i[t] && code == speed_sel_pkg::CODE_EXTENSION;
    assign hit_jog[t]    = terminal_i[t] && code == speed_sel_pkg::CODE_JOG;
    assign hit_second[t] = terminal_i[t] && code == speed_sel_pkg::CODE_SECOND;
  end

  logic sig_low;
  logic sig_middle;
  logic sig_high;
  logic sig_ext;
  logic sig_jog;
  logic sig_second;

  assign sig_low    = |hit_low;
  assign sig_middle = |hit_middle;
  assign sig_high   = |hit_high;
  assign sig_ext    = |hit_ext;
  assign sig_jog    = |hit_jog;
  assign sig_second = |hit_second;

  ////////////////////////////////////////////////////////////////////////
  // mode qualifiers
  logic remote_on;
  logic multi_on;
  logic jog_allowed;

  assign remote_on   = (state.remote_sel != 2'h0);
  assign multi_on    = !remote_on && (state.op_mode == speed_sel_pkg::MODE_EXTERNAL ||
                       state.op_mode == speed_sel_pkg::MODE_COMBINED3 ||
                       state.op_mode == speed_sel_pkg::MODE_COMBINED4);
  assign jog_allowed = (state.op_mode != speed_sel_pkg::MODE_COMBINED3);

  // selectors only reach the table while multi-speed is in force
  assign lk.sel = multi_on ? {sig_ext, sig_high, sig_middle, sig_low} : 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // bus decode; one wait cycle lets the read mux settle into a flop
  logic        bus_req;
  logic        bus_done;
  logic        is_preset;
  logic [3:0]  preset_idx;
  logic [7:0]  preset_ofs;

  assign bus_req    = avs_read_i || avs_write_i;
  assign bus_done   = bus_req && !state.waitrequest;
  assign preset_ofs = avs_address_i - speed_sel_pkg::OFS_PRESET_BASE;
  assign preset_idx = preset_ofs[5:2];
  assign is_preset  = avs_address_i >= speed_sel_pkg::OFS_PRESET_BASE &&
                      avs_address_i <= speed_sel_pkg::OFS_PRESET_LAST &&
                      avs_address_i[1:0] == 2'h0;
  assign lk.rd_idx  = preset_idx;

  // byte-lane merge of a write into the present register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? wdata[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  logic [31:0] rd_value;
  logic [31:0] wr_value;
  logic        gen_ok;
  logic        freq_ok;
  logic        preset_ok;

  // readback of the addressed register; unmapped words read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (avs_address_i)
      speed_sel_pkg::OFS_CONTROL: begin
        rd_value[speed_sel_pkg::CTL_MODE_LSB +: 3]   = state.op_mode;
        rd_value[speed_sel_pkg::CTL_REMOTE_LSB +: 2] = state.remote_sel;
        rd_value[speed_sel_pkg::CTL_WRITE_LSB +: 2]  = state.write_sel;
      end
      speed_sel_pkg::OFS_TERMINALS: rd_value[19:0] = state.term_codes;
      speed_sel_pkg::OFS_JOG_FREQ:  rd_value[15:0] = state.jog_freq;
      speed_sel_pkg::OFS_JOG_TIME:  rd_value[15:0] = state.jog_time;
      speed_sel_pkg::OFS_RAMP_REF:  rd_value[15:0] = state.ramp_ref;
      speed_sel_pkg::OFS_STATUS:
        rd_value[5:0] = {multi_on, remote_on, state.jog_active,
                         state.reverse, state.run, state.reject};
      speed_sel_pkg::OFS_COMMAND:
        rd_value[23:0] = {state.speed, 1'b0, state.source, state.freq_cmd};
      default: begin
        if (is_preset) begin
          rd_value[15:0] = lk.rd_data;
        end
      end
    endcase
  end

  // general settings obey the write selection; presets never do
  assign wr_value  = merge(rd_value, avs_writedata_i, avs_byteenable_i);
  assign gen_ok    = state.write_sel == speed_sel_pkg::WRITE_ANY ||
                     (state.write_sel == speed_sel_pkg::WRITE_STOPPED && !state.run);
  assign freq_ok   = wr_value[15:0] <= speed_sel_pkg::FREQ_MAX && wr_value[31:16] == 16'h0000;
  assign preset_ok = freq_ok || (preset_idx >= 4'h3 &&
                     wr_value == {16'h0000, speed_sel_pkg::NOT_SELECTED});

  assign lk.wr_en   = bus_done && avs_write_i && is_preset && preset_ok;
  assign lk.wr_idx  = preset_idx;
  assign lk.wr_data = wr_value[15:0];

  ////////////////////////////////////////////////////////////////////////
  // next state: bus handshake, settings, then the frequency command
  always_comb begin
    logic        jog_sel;
    logic        start_held;
    logic        bad;
    jog_sel    = 1'b0;
    start_held = 1'b0;
    bad        = 1'b0;
    next_state = state;

    // handshake: request seen with waitrequest high, answered next cycle
    if (bus_req && state.waitrequest) begin
      next_state.waitrequest = 1'b0;
      next_state.readdata    = avs_read_i ? rd_value : 32'h0000_0000;
    end else begin
      next_state.waitrequest = 1'b1;
    end

    // register writes; a refused value is not stored; a refused mode or remote selection drops both, while a valid write_sel is still stored
    if (bus_done && avs_write_i) begin
      unique case (avs_address_i)
        speed_sel_pkg::OFS_CONTROL: begin
          next_state.write_sel = wr_value[speed_sel_pkg::CTL_WRITE_LSB +: 2];
          if (wr_value[speed_sel_pkg::CTL_WRITE_LSB +: 2] > speed_sel_pkg::WRITE_ANY) begin
            next_state.write_sel = state.write_sel;
            bad = 1'b1;
          end
          if (gen_ok && wr_value[speed_sel_pkg::CTL_MODE_LSB +: 3] <= speed_sel_pkg::MODE_MAX &&
              wr_value[speed_sel_pkg::CTL_REMOTE_LSB +: 2] <= speed_sel_pkg::REMOTE_MAX) begin
            next_state.op_mode    = wr_value[speed_sel_pkg::CTL_MODE_LSB +: 3];
            next_state.remote_sel = wr_value[speed_sel_pkg::CTL_REMOTE_LSB +: 2];
          end else begin
            bad = 1'b1;
          end
        end
        speed_sel_pkg::OFS_TERMINALS: begin
          if (gen_ok) next_state.term_codes = wr_value[19:0];
          else        bad = 1'b1;
        end
        speed_sel_pkg::OFS_JOG_FREQ: begin
          if (gen_ok && freq_ok) next_state.jog_freq = wr_value[15:0];
          else                   bad = 1'b1;
        end
        speed_sel_pkg::OFS_JOG_TIME: begin
          if (gen_ok && wr_value[15:0] <= speed_sel_pkg::RAMP_TIME_MAX &&
              wr_value[31:16] == 16'h0000) begin
            next_state.jog_time = wr_value[15:0];
          end else begin
            bad = 1'b1;
          end
        end
        speed_sel_pkg::OFS_RAMP_REF: begin
          if (gen_ok && freq_ok) next_state.ramp_ref = wr_value[15:0];
          else                   bad = 1'b1;
        end
        default: begin
          if (is_preset && !preset_ok) bad = 1'b1;
        end
      endcase
    end

    // sticky refusal flag: write one to clear, a new refusal wins
    if (bus_done && avs_write_i && avs_address_i == speed_sel_pkg::OFS_STATUS &&
        avs_byteenable_i[0] && avs_writedata_i[0]) begin
      next_state.reject = 1'b0;
    end
    if (bad) begin
      next_state.reject = 1'b1;
    end

    // jog from terminal or panel; panel jog runs on the panel button
    jog_sel    = jog_allowed && (sig_jog || panel_jog_mode_i);
    start_held = (panel_jog_mode_i && jog_allowed) ? panel_run_i :
                 (forward_start_i ^ reverse_start_i);

    // both start inputs together count as stop
    next_state.run        = start_held;
    next_state.reverse    = !panel_jog_mode_i && reverse_start_i && !forward_start_i;
    next_state.jog_active = jog_sel;

    // command source by priority
    if (jog_sel) begin
      next_state.source   = speed_sel_pkg::SRC_JOG;
      next_state.freq_cmd = state.jog_freq;
      next_state.speed    = 4'h0;
    end else if (lk.sel_valid) begin
      next_state.source   = speed_sel_pkg::SRC_MULTI;
      next_state.freq_cmd = lk.sel_freq;
      next_state.speed    = lk.sel_speed;
    end else if (current_analog_en_i) begin
      next_state.source   = speed_sel_pkg::SRC_CURRENT;
      next_state.freq_cmd = current_analog_freq_i;
      next_state.speed    = 4'h0;
    end else begin
      next_state.source   = speed_sel_pkg::SRC_VOLTAGE;
      next_state.freq_cmd = voltage_analog_freq_i;
      next_state.speed    = 4'h0;
    end

    // second functions stay live, but the second ramp is held off in jog
    next_state.second_fn   = sig_second;
    next_state.second_ramp = sig_second && !jog_sel;

    // remote setting reuses the three single selectors
    next_state.remote_up    = remote_on && sig_high;
    next_state.remote_down  = remote_on && sig_middle;
    next_state.remote_clear = remote_on && sig_low;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign avs_readdata_o    = state.readdata;
  assign avs_waitrequest_o = state.waitrequest;
  assign freq_command_o    = state.freq_cmd;
  assign command_source_o  = state.source;
  assign speed_number_o    = state.speed;
  assign run_o             = state.run;
  assign reverse_o         = state.reverse;
  assign jog_active_o      = state.jog_active;
  assign jog_accel_time_o  = state.jog_time;
  assign jog_decel_time_o  = state.jog_time;
  assign ramp_ref_freq_o   = state.ramp_ref;
  assign second_function_o = state.second_fn;
  assign second_ramp_o     = state.second_ramp;
  assign remote_up_o       = state.remote_up;
  assign remote_down_o     = state.remote_down;
  assign remote_clear_o    = state.remote_clear;

endmodule

`default_nettype wire

// file: tb/terminal_speed_command_selector_checker.sv
`timescale 1ns/1ps
`default_nettype none
module terminal_speed_command_selector_checker (
  input wire logic        core_clk_i, reset_i, avs_read_i, avs_waitrequest_o,
  input wire logic        forward_start_i, reverse_start_i, panel_run_i, run_o,
  input wire logic        jog_active_o, second_function_o, second_ramp_o, remote_up_o,
  input wire logic [2:0]  command_source_o,
  input wire logic [3:0]  speed_number_o,
  input wire logic [15:0] jog_accel_time_o, jog_decel_time_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_read_one_wait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("read answer late");
  a_wait_short_low: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
  a_ramp_shared: assert property (jog_accel_time_o == jog_decel_time_o) else $error("jog ramp times differ");
  a_second_ramp_jog: assert property (second_ramp_o == (second_function_o && !jog_active_o)) else $error("second ramp in jog");
  a_run_needs_start: assert property (run_o |-> $past(forward_start_i ^ reverse_start_i) || $past(panel_run_i)) else $error("run without start");
  a_remote_no_multi: assert property (remote_up_o |-> command_source_o != 3'h2) else $error("multi while remote");
  a_speed_is_multi: assert property (speed_number_o != 4'h0 |-> command_source_o == 3'h2) else $error("speed without multi");
  a_jog_top_source: assert property (jog_active_o |-> command_source_o == 3'h1) else $error("jog not first");
  c_jog: cover property (jog_active_o && run_o);
  c_speed8: cover property (speed_number_o == 4'h8);
  c_remote: cover property (remote_up_o);
endmodule
bind terminal_speed_command_selector terminal_speed_command_selector_checker chk_u (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
  .avs_waitrequest_o(avs_waitrequest_o), .forward_start_i(forward_start_i),
  .reverse_start_i(reverse_start_i), .panel_run_i(panel_run_i), .run_o(run_o),
  .jog_active_o(jog_active_o), .second_function_o(second_function_o),
  .second_ramp_o(second_ramp_o), .remote_up_o(remote_up_o),
  .command_source_o(command_source_o), .speed_number_o(speed_number_o),
  .jog_accel_time_o(jog_accel_time_o), .jog_decel_time_o(jog_decel_time_o));
`default_nettype wire

// file: tb/contact_model.sv
`timescale 1ns/1ps
`default_nettype none
module contact_model (
  input  wire logic       core_clk_i,
  input  wire logic [8:0] want_i,
  output logic      [8:0] contact_o
);
  // contacts settle one clock after the controller asks, no bounce modelled
  always_ff @(posedge core_clk_i) begin
    contact_o <= want_i;
  end
endmodule
`default_nettype wire

// file: tb/terminal_speed_command_selector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module terminal_speed_command_selector_tb_top;
  logic clk = 0, rst = 1, rd = 0, wr = 0, cur_en = 0, ws;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [8:0] want = 9'h000, con;
  logic [15:0] freq;
  logic [3:0] spd;
  logic [2:0] src;
  logic run, rup;
  int err_count = 0, checked = 0;
  contact_model pm_u (.core_clk_i(clk), .want_i(want), .contact_o(con));
  terminal_speed_command_selector dut_u (.core_clk_i(clk), .reset_i(rst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(ws),
    .terminal_i(con[4:0]), .forward_start_i(con[5]), .reverse_start_i(con[6]),
    .panel_jog_mode_i(con[7]), .panel_run_i(con[8]), .current_analog_en_i(cur_en),
    .current_analog_freq_i(16'h0456), .voltage_analog_freq_i(16'h0123),
    .freq_command_o(freq), .command_source_o(src), .speed_number_o(spd), .run_o(run),
    .reverse_o(), .jog_active_o(), .jog_accel_time_o(), .jog_decel_time_o(),
    .ramp_ref_freq_o(), .second_function_o(), .second_ramp_o(), .remote_up_o(rup),
    .remote_down_o(), .remote_clear_o());
  initial begin
    forever #4 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a; wr <= w; rd <= !w; wd <= d;
    @(posedge clk);
    while (ws !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0; rd <= 1'b0;
  endtask
  task put(input logic [8:0] v);
    want <= v;
    repeat (4) @(posedge clk);
  endtask
  task results;
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_single;
    logic [4:0] p[5] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06};
    logic [15:0] f[5] = '{16'h0064, 16'h012C, 16'h0258, 16'h0064, 16'h012C};
    bus(1, 8'h00, 32'h2);
    for (int i = 0; i < 5; i++) begin
      put({4'h0, p[i]});
      chk("freq", freq, f[i]);
    end
  endtask
  task t_ext;
    bus(1, 8'h04, 32'h00058210);
    put(9'h008);
    chk("freq", freq, 16'h0064);
    bus(1, 8'h5C, 32'h000001F4);
    put(9'h008);
    chk("freq", freq, 16'h01F4);
    chk("speed", spd, 4'h8);
    bus(1, 8'h40, 32'h00000FA1);
    bus(0, 8'h14, 32'h0);
    chk("reject", q[0], 1'b1);
    bus(0, 8'h40, 32'h0);
    chk("high", q, 32'h00000258);
    bus(0, 8'h0C, 32'h0);
    chk("jogtime", q, 32'h00000005);
    bus(0, 8'hFC, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task t_jog;
    put(9'h031);
    chk("src", src, 3'h1);
    chk("freq", freq, 16'h0032);
    chk("run", run, 1'b1);
    put(9'h011);
    chk("run", run, 1'b0);
    bus(1, 8'h00, 32'h3);
    put(9'h031);
    chk("src", src, 3'h2);
    bus(1, 8'h44, 32'h0000012D);
    bus(0, 8'h44, 32'h0);
    chk("middle", q, 32'h0000012D);
    bus(1, 8'h00, 32'h0);
    bus(0, 8'h00, 32'h0);
    chk("mode", q, 32'h00000003);
    put(9'h000);
    bus(1, 8'h00, 32'h0);
    put(9'h180);
    chk("src", src, 3'h1);
    chk("run", run, 1'b1);
  endtask
  task t_mode;
    put(9'h001);
    chk("src", src, 3'h4);
    cur_en <= 1'b1;
    put(9'h001);
    chk("freq", freq, 16'h0456);
    bus(1, 8'h00, 32'h12);
    put(9'h004);
    chk("up", rup, 1'b1);
    chk("src", src, 3'h3);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_single;
    t_ext;
    t_jog;
    t_mode;
    results;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    results;
  end
endmodule
`default_nettype wire
